// ===== hdl/tpio_pkg.sv
// package for the test port and pin control block
package tpio_pkg;
    // ieee 1149.1 controller states
    typedef enum logic [3:0] {
        TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR, TAP_PAUSE_DR,
        TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR, TAP_EXIT1_IR,
        TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
    } tpio_tap_type;
    localparam int IR_WIDTH = 2;
    localparam logic [1:0] IR_RESET = 2'h1;
    localparam logic [1:0] IR_CAPTURE = 2'h1;
    localparam logic [1:0] IR_IDCODE = 2'h1;
    localparam logic [1:0] IR_BYPASS = 2'h3;
    localparam logic [31:0] IDCODE_RESET = 32'h00000001; // arbitrary value, not a real maker code
    // pins from the test controller, raw
    typedef struct packed {
        logic test_clock;
        logic test_mode_select;
        logic test_data_in;
        logic test_port_reset_n;
    } tpio_pins_type;
    typedef struct packed {
        logic test_data_out;
        logic test_data_out_oe;
    } tpio_tdo_type;
endpackage

// ===== hdl/tpio_test_port.sv
// test access port with digital pin float and chip reset control
// What this block does
// - test reset low forces the controller to reset on the third clk_sys edge, no test clock needed
// - mode select sampled on rising test clock steps the 1149.1 states
// - data in is captured on rising test clock edges
// - data out changes on falling test clock edges
// - digital pins float while digital enable and test reset are both low
// - test reset low returns the device to normal operation
// - chip reset low drives core reset low; the test port state is not cleared
module tpio_test_port #(
    parameter logic [31:0] ID_VALUE = tpio_pkg::IDCODE_RESET
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic chip_reset_n,
    input wire logic digital_pin_enable,
    input wire tpio_pkg::tpio_pins_type pins,
    output tpio_pkg::tpio_tdo_type tdo,
    output logic digital_pins_float,
    output logic test_mode_active,
    output logic core_reset_n
);
    import tpio_pkg::*;

    typedef struct packed {
        logic [1:0] clk_s, tms_s, tdi_s, trst_s, den_s, crst_s;
        logic clk_prev;
        tpio_tap_type tap;
        logic [IR_WIDTH-1:0] ir_sh, ir;
        logic [31:0] dr_sh;
        logic tdo_bit, tdo_en;
        logic test_mode;
    } tpio_state_type;

    tpio_state_type s_q, s_d;

    function automatic tpio_tap_type next_tap(input tpio_tap_type t, input logic m);
        unique case (t)
            TAP_RESET: next_tap = m ? TAP_RESET : TAP_IDLE;
            TAP_IDLE: next_tap = m ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: next_tap = m ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: next_tap = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_SHIFT_DR: next_tap = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_EXIT1_DR: next_tap = m ? TAP_UPD_DR : TAP_PAUSE_DR;
            TAP_PAUSE_DR: next_tap = m ? TAP_EXIT2_DR : TAP_PAUSE_DR;
            TAP_EXIT2_DR: next_tap = m ? TAP_UPD_DR : TAP_SHIFT_DR;
            TAP_UPD_DR: next_tap = m ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: next_tap = m ? TAP_RESET : TAP_CAP_IR;
            TAP_CAP_IR: next_tap = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_SHIFT_IR: next_tap = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_EXIT1_IR: next_tap = m ? TAP_UPD_IR : TAP_PAUSE_IR;
            TAP_PAUSE_IR: next_tap = m ? TAP_EXIT2_IR : TAP_PAUSE_IR;
            TAP_EXIT2_IR: next_tap = m ? TAP_UPD_IR : TAP_SHIFT_IR;
            TAP_UPD_IR: next_tap = m ? TAP_SEL_DR : TAP_IDLE;
        endcase
    endfunction

    logic rise, fall, trst_low;

    always_comb begin
        s_d = s_q;
        s_d.clk_s = {s_q.clk_s[0], pins.test_clock};
        s_d.tms_s = {s_q.tms_s[0], pins.test_mode_select};
        s_d.tdi_s = {s_q.tdi_s[0], pins.test_data_in};
        s_d.trst_s = {s_q.trst_s[0], pins.test_port_reset_n};
        s_d.den_s = {s_q.den_s[0], digital_pin_enable};
        s_d.crst_s = {s_q.crst_s[0], chip_reset_n};
        s_d.clk_prev = s_q.clk_s[1];
        rise = s_q.clk_s[1] & ~s_q.clk_prev;
        fall = ~s_q.clk_s[1] & s_q.clk_prev;
        trst_low = ~s_q.trst_s[1];
        if (trst_low) begin
            // edge-free reset; synced so the test clock is not needed
            s_d.tap = TAP_RESET;
            s_d.ir = IR_RESET;
            s_d.tdo_en = 1'b0;
            s_d.test_mode = 1'b0;
        end else begin
            s_d.test_mode = 1'b1;
            if (rise) begin
                s_d.tap = next_tap(s_q.tap, s_q.tms_s[1]);
                unique case (s_q.tap)
                    TAP_RESET: s_d.ir = IR_IDCODE;
                    TAP_CAP_IR: s_d.ir_sh = IR_CAPTURE;
                    TAP_SHIFT_IR: s_d.ir_sh = {s_q.tdi_s[1], s_q.ir_sh[IR_WIDTH-1:1]};
                    TAP_UPD_IR: s_d.ir = s_q.ir_sh;
                    TAP_CAP_DR: s_d.dr_sh = (s_q.ir == IR_IDCODE) ? ID_VALUE : 32'h00000000;
                    TAP_SHIFT_DR: begin
                        if (s_q.ir == IR_IDCODE)
                            s_d.dr_sh = {s_q.tdi_s[1], s_q.dr_sh[31:1]};
                        else
                            s_d.dr_sh[0] = s_q.tdi_s[1];
                    end
                    default: ;
                endcase
            end
            if (fall) begin
                // while test reset is high, output moves only on falling edges
                s_d.tdo_en = (s_q.tap == TAP_SHIFT_IR) || (s_q.tap == TAP_SHIFT_DR);
                s_d.tdo_bit = (s_q.tap == TAP_SHIFT_IR) ? s_q.ir_sh[0] : s_q.dr_sh[0];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            s_q <= '0;
            s_q.tap <= TAP_RESET;
            s_q.ir <= IR_RESET;
            s_q.trst_s <= 2'h0;
            s_q.den_s <= 2'h3;
            s_q.crst_s <= 2'h0;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    assign tdo.test_data_out = s_q.tdo_bit;
    assign tdo.test_data_out_oe = s_q.tdo_en;
    assign digital_pins_float = ~s_q.den_s[1] & ~s_q.trst_s[1];
    assign test_mode_active = s_q.test_mode;
    assign core_reset_n = s_q.crst_s[1]; // holds the core in reset; the test port is not reset by it
endmodule

// ===== sim/tpio_ctl_model.sv
// scan controller model driving the test port pins
module tpio_ctl_model (output tpio_pkg::tpio_pins_type pins,
    input wire tpio_pkg::tpio_tdo_type tdo);
    timeunit 1ns;
    timeprecision 1ns;
    initial pins = 4'b0110; // test reset low until raised
    // clock only within a tick, low between; sample 150 ns into the high phase
    task automatic tick(input logic tms, input logic tdi, output logic seen);
        pins.test_mode_select = tms;
        pins.test_data_in = tdi;
        #200 pins.test_clock = 1'b1;
        #150 seen = tdo.test_data_out_oe ? tdo.test_data_out : 1'bz;
        #50 pins.test_clock = 1'b0;
    endtask
endmodule

// ===== sim/tpio_monitor.sv
// assertion checker for the test port block
module tpio_monitor (input wire logic clk_sys,
    input wire logic rstn,
    input wire logic chip_reset_n,
    input wire logic digital_pin_enable,
    input wire tpio_pkg::tpio_pins_type pins,
    input wire tpio_pkg::tpio_tdo_type tdo,
    input wire logic digital_pins_float,
    input wire logic test_mode_active,
    input wire logic core_reset_n);
    import tpio_pkg::*;
    wire trst_n = pins.test_port_reset_n;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    tap_reset_a: assert property (!trst_n [*5] |-> !tdo.test_data_out_oe) else $error("oe");
    float_on_a: assert property ((!digital_pin_enable && !trst_n) [*5] |-> digital_pins_float) else $error("fl");
    float_off_a: assert property ((digital_pin_enable || trst_n) [*5] |-> !digital_pins_float) else $error("fl");
    mode_on_a: assert property (trst_n [*5] |-> test_mode_active) else $error("mode");
    mode_off_a: assert property (!trst_n [*5] |-> !test_mode_active) else $error("mode");
    core_hold_a: assert property (!chip_reset_n [*5] |-> !core_reset_n) else $error("core");
    core_run_a: assert property (chip_reset_n [*5] |-> core_reset_n) else $error("core");
    tdo_edge_a: assert property (trst_n && $changed(tdo) |-> !pins.test_clock) else $error("tdo");
    cover property ($rose(tdo.test_data_out_oe));
    cover property ($rose(digital_pins_float));
    cover property ($rose(core_reset_n));
endmodule
bind tpio_test_port tpio_monitor mon (.clk_sys, .rstn, .chip_reset_n, .digital_pin_enable, .pins, .tdo,
    .digital_pins_float, .test_mode_active, .core_reset_n);

// ===== sim/test_port_and_io_control_tb.sv
// self-checking bench for the test port block
module test_port_and_io_control_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import tpio_pkg::*;
    logic clk_sys = 1'b0, rstn = 1'b0, chip_reset_n = 1'b0, digital_pin_enable = 1'b1;
    logic digital_pins_float, test_mode_active, core_reset_n;
    tpio_pins_type pins;
    tpio_tdo_type tdo;
    int errors = 0, checks_done = 0;
    logic [31:0] v;
    tpio_test_port #(.ID_VALUE(32'h5A3C0F01)) uut (.clk_sys, .rstn, .clk_en(1'b1), .chip_reset_n,
        .digital_pin_enable, .pins, .tdo, .digital_pins_float, .test_mode_active, .core_reset_n);
    tpio_ctl_model ctl (.pins, .tdo);
    initial forever #25 clk_sys = ~clk_sys;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) $display("BAD %0t %h %h", $time, seen, exp);
        errors += (seen !== exp);
    endtask
    task automatic seq(input logic [31:0] tms, input logic [31:0] din, input int n);
        v = '0;
        for (int i = 0; i < n; i++) ctl.tick(tms[i], din[i], v[i]);
    endtask
    // expect {float, core reset, test mode}
    task automatic pins_test(input logic en, input logic rst_n, input logic trst, input logic [2:0] exp);
        @(negedge clk_sys);
        {digital_pin_enable, chip_reset_n, ctl.pins.test_port_reset_n} = {en, rst_n, trst};
        repeat (6) @(negedge clk_sys);
        check({digital_pins_float, core_reset_n, test_mode_active}, exp);
        check(tdo.test_data_out_oe, 1'b0);
        $display("pins test %b%b%b done", en, rst_n, trst);
    endtask
    task automatic scan_test();
        seq(32'h05F, 32'h0, 9);
        seq(32'h80000000, 32'h0, 32);
        check(v, 32'h5A3C0F01);
        seq(32'h07, 32'h0, 5);
        check(v[0], 1'bz);
        seq(32'h2, 32'h3, 2);
        check(v, IR_CAPTURE);
        seq(32'h3, 32'h0, 4);
        // stay in shift so the reset below cuts a live transfer
        seq(32'h0, 32'h0F3, 9);
        check(v, 32'h1E6);
        $display("scan test done");
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        #200000;
        errors++;
        conclude();
    end
    initial begin
        repeat (5) @(negedge clk_sys);
        rstn = 1'b1;
        pins_test(1'b0, 1'b0, 1'b0, 3'b100);
        pins_test(1'b1, 1'b1, 1'b0, 3'b010);
        pins_test(1'b0, 1'b1, 1'b1, 3'b011);
        scan_test();
        pins_test(1'b1, 1'b1, 1'b0, 3'b010);
        conclude();
    end
endmodule
